// ---- rtl/col_test_gen.v ----
// Collision test generator: COL follows TXEN with bounded delays
`include "phy_mgmt_defs.vh"
module col_test_gen #(
	parameter ON_CYC = `COL_ON_CYC
) (
	input wire clk,
	input wire rst_b,
	input wire enable,
	input wire tx_en,
	output reg col
);
	// ==========================================================
	// Delay counter
	reg [3:0] cnt_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 4'h0;
			col <= 1'b0;
		end else if (!enable || !tx_en) begin
			// Drop on the next edge, one cycle after TXEN falls
			cnt_q <= 4'h0;
			col <= 1'b0;
		end else if (cnt_q == ON_CYC[3:0] - 4'h1) begin
			col <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule

// ---- rtl/latch_flag.v ----
// Latching status flag that holds an event until read
module latch_flag #(
	parameter LATCH_HIGH = 1
) (
	input wire clk,
	input wire rst_b,
	input wire live,
	input wire rd_clr,
	input wire flush,
	output reg flag_q
);
	// ==========================================================
	// Latch holds the event value; a read returns to live value
	wire event_on = LATCH_HIGH ? live : ~live;
	reg held_q;
	// Flag follows the next held value so a read clears it at once;
	// a back-to-back read then already sees the live condition
	wire held_d = flush ? 1'b0 :
		event_on ? 1'b1 :
		rd_clr ? 1'b0 : held_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			held_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			// Event arriving on the read cycle is kept
			if (flush)
				held_q <= 1'b0;
			else if (event_on)
				held_q <= 1'b1;
			else if (rd_clr)
				held_q <= 1'b0;
			flag_q <= held_d ? (LATCH_HIGH ? 1'b1 : 1'b0)
				: (LATCH_HIGH ? 1'b0 : 1'b1);
		end
	end
endmodule

// ---- rtl/phy_mgmt_defs.vh ----
// Register addresses, field positions, reset values and timing counts
`ifndef PHY_MGMT_DEFS_VH
`define PHY_MGMT_DEFS_VH

// ==========================================================
// Register addresses
`define ADDR_CONTROL 5'h00
`define ADDR_STATUS 5'h01

// ==========================================================
// Control field positions
`define CTL_LOOPBACK 14
`define CTL_SPEED 13
`define CTL_ANEG_EN 12
`define CTL_DUPLEX 8
`define CTL_COLTEST 7
`define CTL_KEEP_MASK 16'h7180
`define CTL_RESET_VAL 16'h3000

// ==========================================================
// Status field positions
`define ST_T4 15
`define ST_CAP_HI 14
`define ST_CAP_LO 11
`define ST_RSV_HI 10
`define ST_RSV_LO 7
`define ST_PRE_SUPP 6
`define ST_ANEG_DONE 5
`define ST_RFAULT 4
`define ST_ANEG_ABLE 3
`define ST_LINK 2
`define ST_JABBER 1
`define ST_EXT_CAP 0
`define ST_OVR_RESET 16'h7800
`define ST_OVR_MASK 16'h7FC0

// ==========================================================
// Collision test timing
`define BIT_NS 10
`define COL_ON_BITS 512
`define COL_OFF_BITS 4
`define CLK_NS 4
// Assert after 2 cycles, well inside the 512 bit window
`define COL_ON_CYC 2
// Longest drop delay rounds down: 4 bits * 10 ns / 4 ns
`define COL_OFF_CYC ((`COL_OFF_BITS * `BIT_NS) / `CLK_NS)

`endif

// ---- rtl/phy_mgmt_regs.v ----
// Control bits 14, 13, 12, 8 and 7 and status register of the PHY management set
`include "phy_mgmt_defs.vh"
// Contract
// - Autoneg on: duplex from negotiated result (code forces half in loopback)
// - Autoneg off: duplex bit picks half/full
// - Loopback: duplex bit has no effect
// - Collision test off: COL not mirroring TXEN
// - Collision test works even in loopback
// - COL rises within 512 bit times
// - COL falls within 4 bit times
// - Reserved control bits read zero
// - Status at address 1, reset to defaults
// - Four-pair capability bit always zero
// - Capability bits reset one, override-writable
// - Preamble suppression bit resets to zero
// - Negotiation complete latches high, resets zero
// - Remote fault latches high, reset zero
// - Negotiation ability and extended capability one
// - Link status latches low from monitor
// - Status read clears latched remote fault
// - Override writes blocked without enable
// - Autoneg off holds complete bit zero
module phy_mgmt_regs (
	input wire clk,
	input wire rst_b,
	input wire soft_rst,
	input wire [4:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [15:0] reg_wdata,
	output reg [15:0] reg_rdata,
	input wire override_wr_en,
	input wire aneg_done_live,
	input wire aneg_full_duplex,
	input wire partner_fault,
	input wire link_ok,
	input wire jabber_live,
	input wire tx_en,
	input wire mii_col_in,
	output wire mii_col,
	output wire full_duplex,
	output wire aneg_en,
	output wire loopback_en,
	output wire speed_100
);
	// ==========================================================
	// Reset synchroniser
	reg rst_s1_q;
	reg rst_s2_q;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	wire rst_n = rst_s2_q;

	// ==========================================================
	// Access decode
	wire wr_ctl = reg_wr && (reg_addr == `ADDR_CONTROL);
	wire wr_st = reg_wr && (reg_addr == `ADDR_STATUS);
	wire rd_st = reg_rd && (reg_addr == `ADDR_STATUS);

	// ==========================================================
	// Control bits (only those this block keeps)
	reg [15:0] ctl_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ctl_q <= `CTL_RESET_VAL;
		else if (soft_rst)
			ctl_q <= `CTL_RESET_VAL;
		else if (wr_ctl)
			ctl_q <= reg_wdata & `CTL_KEEP_MASK;
	end
	assign aneg_en = ctl_q[`CTL_ANEG_EN];
	assign loopback_en = ctl_q[`CTL_LOOPBACK];
	assign speed_100 = ctl_q[`CTL_SPEED];
	wire col_test = ctl_q[`CTL_COLTEST];

	// Duplex selection; loopback forces half so bit 8 is ignored
	assign full_duplex = loopback_en ? 1'b0 :
		aneg_en ? aneg_full_duplex :
		ctl_q[`CTL_DUPLEX];

	// ==========================================================
	// Collision test
	wire col_gen;
	col_test_gen u_col (
		.clk(clk),
		.rst_b(rst_n),
		.enable(col_test),
		.tx_en(tx_en),
		.col(col_gen)
	);
	// Loopback masks real collisions unless the test overrides
	assign mii_col = col_test ? col_gen :
		(loopback_en ? 1'b0 : mii_col_in);

	// ==========================================================
	// Override-writable status bits
	reg [15:0] ovr_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			ovr_q <= `ST_OVR_RESET;
		else if (soft_rst)
			ovr_q <= `ST_OVR_RESET;
		else if (wr_st && override_wr_en)
			ovr_q <= reg_wdata & `ST_OVR_MASK;
	end

	// ==========================================================
	// Latching flags
	wire done_q;
	wire fault_q;
	wire link_q;
	wire jab_q;
	latch_flag #(.LATCH_HIGH(1)) u_done (
		.clk(clk),
		.rst_b(rst_n),
		.live(aneg_en & aneg_done_live),
		.rd_clr(rd_st),
		.flush(soft_rst | ~aneg_en),
		.flag_q(done_q)
	);
	latch_flag #(.LATCH_HIGH(1)) u_fault (
		.clk(clk),
		.rst_b(rst_n),
		.live(partner_fault),
		.rd_clr(rd_st),
		.flush(soft_rst),
		.flag_q(fault_q)
	);
	latch_flag #(.LATCH_HIGH(0)) u_link (
		.clk(clk),
		.rst_b(rst_n),
		.live(link_ok),
		.rd_clr(rd_st),
		.flush(soft_rst),
		.flag_q(link_q)
	);
	latch_flag #(.LATCH_HIGH(1)) u_jab (
		.clk(clk),
		.rst_b(rst_n),
		.live(jabber_live),
		.rd_clr(rd_st),
		.flush(soft_rst),
		.flag_q(jab_q)
	);

	// ==========================================================
	// Status word assembly
	reg [15:0] status_w;
	always @* begin
		status_w = ovr_q & `ST_OVR_MASK;
		status_w[`ST_T4] = 1'b0;
		status_w[`ST_ANEG_DONE] = done_q & aneg_en;
		status_w[`ST_RFAULT] = fault_q;
		status_w[`ST_ANEG_ABLE] = 1'b1;
		status_w[`ST_LINK] = link_q;
		status_w[`ST_JABBER] = jab_q;
		status_w[`ST_EXT_CAP] = 1'b1;
	end

	// ==========================================================
	// Read data, registered one cycle after the read strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 16'h0000;
		else if (reg_rd) begin
			case (reg_addr)
			`ADDR_CONTROL: reg_rdata <= ctl_q;
			`ADDR_STATUS: reg_rdata <= status_w;
			default: reg_rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// ---- testbench/phy_mgmt_monitor.sv ----
// Port checker for the management register bank
module phy_mgmt_monitor (
	input wire clk,
	input wire rst_b,
	input wire [4:0] reg_addr,
	input wire reg_rd,
	input wire [15:0] reg_rdata,
	input wire aneg_en,
	input wire loopback_en,
	input wire full_duplex,
	input wire aneg_full_duplex,
	input wire partner_fault,
	input wire link_ok
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	wire st_rd = reg_rd && reg_addr == 5'h01;
	// ========
	// Duplex selection
	AST_DUP_ANEG: assert property (
		aneg_en && !loopback_en |-> full_duplex == aneg_full_duplex
	) else $error("duplex not from negotiation");
	AST_DUP_LOOP: assert property (
		loopback_en |-> !full_duplex
	) else $error("duplex bit acted in loopback");
	// ========
	// Read answers
	AST_CTL_RSV: assert property (
		reg_rd && reg_addr == 5'h00 |=> reg_rdata[6:0] == 7'h00
	) else $error("reserved control bits not zero");
	AST_ST_T4: assert property (
		st_rd |=> !reg_rdata[15]
	) else $error("four-pair bit set");
	AST_ST_ONES: assert property (
		st_rd |=> reg_rdata[3] && reg_rdata[0]
	) else $error("ability bits not one");
	AST_ST_DONE_OFF: assert property (
		st_rd && !aneg_en && !$past(aneg_en) |=> !reg_rdata[5]
	) else $error("complete bit set while disabled");
	// Fault held two cycles is surely seen by the flag flop
	AST_ST_FAULT: assert property (
		st_rd && partner_fault && $past(partner_fault) |=> reg_rdata[4]
	) else $error("remote fault not shown");
	AST_ST_LINK: assert property (
		st_rd && !$past(link_ok) && !$past(link_ok, 2) |=> !reg_rdata[2]
	) else $error("link loss not shown");
endmodule
bind phy_mgmt_regs phy_mgmt_monitor phy_mgmt_monitor_i (.clk, .rst_b,
	.reg_addr, .reg_rd, .reg_rdata, .aneg_en, .loopback_en, .full_duplex,
	.aneg_full_duplex, .partner_fault, .link_ok);

// ---- testbench/sta_model.sv ----
// Station management model issuing register accesses
module sta_model (
	input logic clk,
	input logic [15:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [4:0] reg_addr = 5'h00,
	output logic [15:0] reg_wdata = 16'h0000
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		// Reserved control bits always go out at their default zero
		reg_wdata <= (a == 5'h00) ? (v & 16'hFF80) : v;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Return off the edge so caller changes do not race the write
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
endmodule

// ---- testbench/tb_phy_mgmt_regs.sv ----
// Self-checking bench for the management register bank
module tb_phy_mgmt_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_b = 0, ovr = 0, an_dn = 0, an_fd = 0;
	logic pf = 0, lk = 0, tx = 0;
	logic [15:0] d;
	wire reg_wr, reg_rd, mii_col, fdx;
	wire [4:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	int err_count = 0, checks_done = 0;
	always #2 clk = ~clk;
	phy_mgmt_regs phy_mgmt_regs_i (.clk, .rst_b, .soft_rst(1'b0), .reg_addr,
		.reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .override_wr_en(ovr),
		.aneg_done_live(an_dn), .aneg_full_duplex(an_fd), .partner_fault(pf),
		.link_ok(lk), .jabber_live(1'b0), .tx_en(tx), .mii_col_in(1'b0),
		.mii_col, .full_duplex(fdx), .aneg_en(), .loopback_en(),
		.speed_100());
	sta_model sta_model_i (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata);
	task chk(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task rs(input logic [15:0] exp);
		sta_model_i.rd(5'h01, d);
		chk(d, exp);
	endtask
	task cfd(input logic e);
		tick(1);
		chk({15'h0000, fdx}, {15'h0000, e});
	endtask
	task wait_col(input logic v, input int n);
		for (int i = 0; i < n && mii_col !== v; i++)
			tick(1);
		chk({15'h0000, mii_col}, {15'h0000, v});
		if (mii_col !== v)
			end_sim();
	endtask
	initial begin
		tick(16);
		rst_b = 1;
		tick(4);
		rs(16'h7809);
		sta_model_i.rd(5'h00, d);
		chk(d, 16'h3000);
		sta_model_i.rd(5'h05, d);
		chk(d, 16'h0000);
		sta_model_i.wr(5'h01, 16'h0000);
		rs(16'h7809);
		ovr = 1;
		sta_model_i.wr(5'h01, 16'hFFC0);
		rs(16'h7FC9);
		sta_model_i.wr(5'h01, 16'h7800);
		ovr = 0;
		$display("test 1 done");
		lk = 1;
		tick(3);
		sta_model_i.rd(5'h01, d);
		rs(16'h780D);
		lk = 0;
		pf = 1;
		an_dn = 1;
		tick(1);
		lk = 1;
		pf = 0;
		an_dn = 0;
		rs(16'h7839);
		rs(16'h780D);
		pf = 1;
		tick(2);
		rs(16'h781D);
		pf = 0;
		sta_model_i.rd(5'h01, d);
		sta_model_i.rd(5'h01, d);
		rs(16'h780D);
		$display("test 2 done");
		an_fd = 1;
		cfd(1);
		an_fd = 0;
		cfd(0);
		sta_model_i.wr(5'h00, 16'h0100);
		cfd(1);
		an_fd = 1;
		sta_model_i.wr(5'h00, 16'h0000);
		cfd(0);
		sta_model_i.wr(5'h00, 16'h4100);
		cfd(0);
		an_dn = 1;
		tick(2);
		rs(16'h780D);
		an_dn = 0;
		$display("test 3 done");
		sta_model_i.wr(5'h00, 16'h4080);
		tx = 1;
		wait_col(1, 1280);
		tx = 0;
		wait_col(0, 10);
		sta_model_i.wr(5'h00, 16'h0000);
		tx = 1;
		tick(8);
		chk({15'h0000, mii_col}, 16'h0000);
		$display("test 4 done");
		end_sim();
	end
endmodule
